/* dv/pclcr_host_model.sv */
// host controller model for the serial control port: frames, instruction, data bytes
// assumes the bench calls access() from its own process; inputs change at falling clk
`timescale 1ns/1ps
module pclcr_host_model (
    input  wire logic clk,
    output logic      csb_n,
    output logic      sclk,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_pin_oe
);
    // ----------------------------------------------------------------
    // pin resolution
    // ----------------------------------------------------------------
    logic host_val;
    logic host_drv;
    logic line_last = 1'b0;
    logic so_last   = 1'b0;
    logic so_line;

    // undriven lines have no pull: show the inverse of the last level
    assign sdio_in = sdio_oe ? sdio_out : (host_drv ? host_val : ~line_last);
    assign so_line = serial_out_pin_oe ? serial_out_pin : ~so_last;

    always @(posedge clk) begin
        line_last <= sdio_in;
        so_last   <= so_line;
    end

    initial begin
        csb_n     = 1'b1;
        sclk      = 1'b0;
        host_val  = 1'b0;
        host_drv  = 1'b0;
    end

    // ----------------------------------------------------------------
    // one serial bit: sclk low 3 clk, high 3 clk (each level >= 2 clk)
    // ----------------------------------------------------------------
    task automatic xfer(input logic b, input logic rd, input logic bidir, output logic q, inout logic oe);
        @(negedge clk);
        sclk     = 1'b0;
        host_drv = !rd;
        if (!rd) host_val = b;
        repeat (3) @(negedge clk);
        q  = bidir ? sdio_in : so_line;
        oe = oe | sdio_oe;
        sclk = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // instruction r/w, byte count 00, 13-bit address, then one byte; lsb set sends both lsb first
    task automatic access(input logic rd, input logic [12:0] addr, input logic [7:0] wd, input logic bidir,
                          input logic lsb, output logic [7:0] rdat, output logic oe_seen);
        logic [15:0] ins;
        logic        q;
        ins     = {rd, 2'b00, addr};
        oe_seen = 1'b0;
        @(negedge clk);
        csb_n = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 15; i >= 0; i--) xfer(ins[lsb ? 15 - i : i], 1'b0, bidir, q, oe_seen);
        oe_seen = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            xfer(wd[lsb ? 7 - i : i], rd, bidir, q, oe_seen);
            rdat[lsb ? 7 - i : i] = q;
        end
        // close the frame: chip select high, sclk low, host stops driving the data line
        @(negedge clk);
        csb_n    = 1'b1;
        sclk     = 1'b0;
        host_drv = 1'b0;
        repeat (3) @(negedge clk);
    endtask
endmodule

/* dv/pclcr_regs_tb.sv */
// self-checking bench for the divider / reference-loss register slice
// assumes the host model for serial traffic; monitor inputs driven here
`timescale 1ns/1ps
module pclcr_regs_tb;
    import pclcr_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic csb_n, sclk, sdio_in, sdio_out, sdio_oe, so_pin, so_oe;
    logic tick_p = 1'b0;
    logic lock = 1'b0;
    logic miss = 1'b0;
    logic [3:0] sel = 4'h0;
    logic mon, stat, last_oe;
    logic lsbf = 1'b0;
    pclcr_divider_s div;
    pclcr_lor_cfg_s lcfg;
    int   err_count = 0;
    int   checks_done = 0;
    int   waits[4] = '{3, 6, 12, 24};
    logic [7:0] rst_map[8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    pclcr_regs u_dut (.clk(clk), .rst(rst), .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(so_pin), .serial_out_pin_oe(so_oe),
        .phase_detector_tick(tick_p), .lock_detect(lock), .reference_missing(miss),
        .status_pin_select(sel), .divider(div), .lor_cfg(lcfg), .reference_loss_monitor(mon),
        .status_pin(stat));

    pclcr_host_model u_host (.clk(clk), .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(so_pin), .serial_out_pin_oe(so_oe));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(1'b0, a, d, 1'b0, lsbf, q, last_oe);
    endtask

    task automatic rd(input logic [12:0] a, input logic bd, input logic [7:0] e, input string w);
        logic [7:0] q;
        u_host.access(1'b1, a, 8'h00, bd, lsbf, q, last_oe);
        chk(w, {24'h0, e}, {24'h0, q});
    endtask

    // one phase detector cycle, reference edge present or missing
    task automatic pd_tick(input logic m);
        @(negedge clk);
        tick_p = 1'b1;
        miss   = m;
        @(negedge clk);
        tick_p = 1'b0;
        miss   = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk("so_oe reset", 1, so_oe);
        chk("divider reset", 0, div);
        chk("lor_cfg reset", 0, lcfg);
        for (int i = 0; i < 8; i++) rd(13'(i), 1'b0, rst_map[i], "reset map");
        $display("test reset done");

        for (int i = 1; i < 4; i++) wr(13'(i), 8'hff);
        for (int i = 1; i < 4; i++) rd(13'(i), 1'b0, 8'h00, "unused slot");
        wr(SWALLOW_COUNT_OFS, 8'hff);
        wr(MAIN_COUNT_HIGH_OFS, 8'hff);
        wr(MAIN_COUNT_LOW_OFS, 8'ha5);
        chk("divider", {13'h0, 6'h3f, 13'h1fa5}, div);
        rd(SWALLOW_COUNT_OFS, 1'b0, 8'h3f, "swallow rd");
        rd(MAIN_COUNT_HIGH_OFS, 1'b0, 8'h1f, "main hi rd");
        rd(MAIN_COUNT_LOW_OFS, 1'b0, 8'ha5, "main lo rd");
        wr(REFERENCE_LOSS_CONTROL_OFS, 8'hff);
        rd(REFERENCE_LOSS_CONTROL_OFS, 1'b0, 8'h64, "lor ctrl rd");
        chk("lor_cfg", 3'h7, lcfg);
        chk("uni oe", 0, last_oe);
        $display("test divider done");

        // monitor off: missing edges never raise the flag
        wr(REFERENCE_LOSS_CONTROL_OFS, 8'h00);
        lock = 1'b1;
        repeat (30) pd_tick(1'b1);
        chk("mon disabled", 0, mon);
        for (int c = 0; c < 4; c++) begin
            lock = 1'b0;
            wr(REFERENCE_LOSS_CONTROL_OFS, {1'b0, c[1:0], 5'h04});
            lock = 1'b1;
            repeat (waits[c]) pd_tick(1'b1);
            chk("mon in delay", 0, mon);
            pd_tick(1'b1);
            chk("mon armed", 1, mon);
            sel = STATUS_SEL_LOR;
            repeat (2) @(negedge clk);
            chk("status lor", 1, stat);
            sel = 4'h9;
            repeat (2) @(negedge clk);
            chk("status other", 0, stat);
            wr(REFERENCE_LOSS_CONTROL_OFS, 8'h00);
            chk("mon cleared", 0, mon);
        end
        sel = STATUS_SEL_LOR;
        repeat (2) @(negedge clk);
        chk("status idle", 0, stat);
        $display("test monitor done");

        wr(REFERENCE_LOSS_CONTROL_OFS, 8'h24);
        wr(SERIAL_PORT_CONFIG_OFS, 8'ha0);
        chk("soft div", 0, div);
        chk("soft lor", 0, lcfg);
        chk("bidir so_oe", 0, so_oe);
        wr(MAIN_COUNT_HIGH_OFS, 8'h11);
        rd(MAIN_COUNT_HIGH_OFS, 1'b1, 8'h00, "soft lost");
        chk("bidir oe", 1, last_oe);
        rd(SERIAL_PORT_CONFIG_OFS, 1'b1, 8'hb0, "cfg kept");
        wr(SERIAL_PORT_CONFIG_OFS, 8'h80);
        rd(SERIAL_PORT_CONFIG_OFS, 1'b1, 8'h90, "cfg bidir");
        wr(MAIN_COUNT_HIGH_OFS, 8'h11);
        chk("after soft", 13'h1100, div.main_count);
        wr(SERIAL_PORT_CONFIG_OFS, 8'h00);
        chk("uni so_oe", 1, so_oe);
        rd(MAIN_COUNT_HIGH_OFS, 1'b0, 8'h11, "uni rd");
        chk("uni no oe", 0, last_oe);
        $display("test soft reset done");

        // lsb-first framing: instruction and data reversed on the wire
        wr(SERIAL_PORT_CONFIG_OFS, 8'h40);
        lsbf = 1'b1;
        wr(SWALLOW_COUNT_OFS, 8'h2c);
        rd(SWALLOW_COUNT_OFS, 1'b0, 8'h2c, "lsb swallow");
        rd(SERIAL_PORT_CONFIG_OFS, 1'b0, 8'h50, "lsb cfg");
        wr(SERIAL_PORT_CONFIG_OFS, 8'h00);
        lsbf = 1'b0;
        chk("lsb div", {13'h0, 6'h2c, 13'h1100}, div);
        rd(SWALLOW_COUNT_OFS, 1'b0, 8'h2c, "msb swallow");
        $display("test lsb first done");
        report_and_stop();
    end

    // watchdog: the tests need roughly 7500 cycles
    initial begin
        #250000;
        err_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule

/* verilog/pclcr_pkg.sv */
// register constants, types and field layout for the divider / reference-loss config slice
// assumes a 200 MHz system clock and a host on a three/four-wire serial port
// Functional notes
// - bidirectional mode: serial out pin off, data on data pin
// - unidirectional mode: serial out pin drives read data
// - unidirectional mode is the reset default
// - swallow count 0x04[5:0], main high 0x05[4:0]
// - main count low eight bits at 0x06
// - monitor runs only with 0x07[2]; default off
// - post-lock wait 3/6/12/24 phase detector cycles
// - soft reset restores all but 0x00; not self-clearing
// - status select 1010 outputs loss flag high
package pclcr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [12:0] SERIAL_PORT_CONFIG_OFS     = 13'h0000;
    localparam logic [12:0] SWALLOW_COUNT_OFS          = 13'h0004;
    localparam logic [12:0] MAIN_COUNT_HIGH_OFS        = 13'h0005;
    localparam logic [12:0] MAIN_COUNT_LOW_OFS         = 13'h0006;
    localparam logic [12:0] REFERENCE_LOSS_CONTROL_OFS = 13'h0007;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SPC_SDO_INACTIVE_BIT = 7;
    localparam int SPC_LSB_FIRST_BIT    = 6;
    localparam int SPC_SOFT_RESET_BIT   = 5;
    localparam int SPC_LONG_INSTR_BIT   = 4;
    localparam int RLC_ENABLE_BIT       = 2;
    localparam int RLC_DELAY_LSB        = 5;
    localparam int INSTR_RW_BIT         = 15;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic        SDO_INACTIVE_RST = 1'b0;
    localparam logic        LSB_FIRST_RST    = 1'b0;
    localparam logic        SOFT_RESET_RST   = 1'b0;
    localparam logic [5:0]  SWALLOW_RST      = 6'h00;
    localparam logic [12:0] MAIN_COUNT_RST   = 13'h0000;
    localparam logic        LOR_ENABLE_RST   = 1'b0;
    localparam logic [1:0]  LOR_DELAY_RST    = 2'h0;

    // ----------------------------------------------------------------
    // counts and codes
    // ----------------------------------------------------------------
    localparam logic [4:0] LOR_WAIT_CODE0 = 5'h03;
    localparam logic [4:0] LOR_WAIT_CODE1 = 5'h06;
    localparam logic [4:0] LOR_WAIT_CODE2 = 5'h0c;
    localparam logic [4:0] LOR_WAIT_CODE3 = 5'h18;
    localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
    localparam logic [3:0] DATA_LAST_BIT  = 4'h7;
    localparam logic [3:0] STATUS_SEL_LOR = 4'ha;

    typedef enum logic [2:0] {
        PCLCR_IDLE  = 3'b001,
        PCLCR_INSTR = 3'b010,
        PCLCR_DATA  = 3'b100
    } pclcr_state_e;

    typedef struct packed {
        logic [5:0]  swallow_count;
        logic [12:0] main_count;
    } pclcr_divider_s;

    typedef struct packed {
        logic       enable;
        logic [1:0] delay_code;
    } pclcr_lor_cfg_s;

endpackage

/* verilog/pclcr_regs.sv */
// serial-port register slice: port config, feedback divider counts, reference-loss monitor
// assumes serial pins already synchronous to clk; sclk must stay at each level >= 2 clk cycles
`timescale 1ns/1ps
module pclcr_regs
    import pclcr_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     csb_n,
    input  wire logic                     sclk,
    input  wire logic                     sdio_in,
    output logic                          sdio_out,
    output logic                          sdio_oe,
    output logic                          serial_out_pin,
    output logic                          serial_out_pin_oe,
    input  wire logic                     phase_detector_tick,
    input  wire logic                     lock_detect,
    input  wire logic                     reference_missing,
    input  wire logic [3:0]               status_pin_select,
    output pclcr_pkg::pclcr_divider_s     divider,
    output pclcr_pkg::pclcr_lor_cfg_s     lor_cfg,
    output logic                          reference_loss_monitor,
    output logic                          status_pin
);
    import pclcr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pclcr_state_e   state_reg;
    logic           sclk_prev_reg;
    logic [3:0]     bit_cnt_reg;
    logic [14:0]    shift_reg;
    logic           read_reg;
    logic [12:0]    addr_reg;
    logic [7:0]     out_byte_reg;
    logic           sdo_inactive_reg;
    logic           lsb_first_reg;
    logic           soft_reset_reg;
    pclcr_divider_s divider_reg;
    pclcr_lor_cfg_s lor_cfg_reg;
    logic [4:0]     lor_cnt_reg;
    logic           lor_armed_reg;
    logic           lor_flag_reg;
    logic           status_pin_reg;
    logic           sdio_out_reg;
    logic           sdio_oe_reg;
    logic           sdo_out_reg;
    logic           sdo_oe_reg;

    logic           sclk_rise;
    logic           sclk_fall;
    logic [15:0]    instr_raw;
    logic [15:0]    instr_word;
    logic [7:0]     data_raw;
    logic [7:0]     data_byte;
    logic           instr_done;
    logic           byte_done;
    logic           wr_now;
    logic [12:0]    first_addr;
    logic [12:0]    next_addr;
    logic [4:0]     lor_wait;
    logic [2:0]     out_idx;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // unmapped and unused locations read zero, long instruction reads one
    function automatic logic [7:0] read_mux(input logic [12:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            SERIAL_PORT_CONFIG_OFS: begin
                d[SPC_SDO_INACTIVE_BIT] = sdo_inactive_reg;
                d[SPC_LSB_FIRST_BIT]    = lsb_first_reg;
                d[SPC_SOFT_RESET_BIT]   = soft_reset_reg;
                d[SPC_LONG_INSTR_BIT]   = 1'b1;
            end
            SWALLOW_COUNT_OFS:          d[5:0] = divider_reg.swallow_count;
            MAIN_COUNT_HIGH_OFS:        d[4:0] = divider_reg.main_count[12:8];
            MAIN_COUNT_LOW_OFS:         d      = divider_reg.main_count[7:0];
            REFERENCE_LOSS_CONTROL_OFS: begin
                d[RLC_ENABLE_BIT]              = lor_cfg_reg.enable;
                d[RLC_DELAY_LSB + 1 -: 2]      = lor_cfg_reg.delay_code;
            end
            default:                    d      = 8'h00;
        endcase
        return d;
    endfunction

    // ----------------------------------------------------------------
    // serial framing
    // ----------------------------------------------------------------
    assign sclk_rise  = sclk & ~sclk_prev_reg;
    assign sclk_fall  = ~sclk & sclk_prev_reg;
    assign instr_raw  = {shift_reg, sdio_in};
    assign instr_word = lsb_first_reg ? rev16(instr_raw) : instr_raw;
    assign data_raw   = {shift_reg[6:0], sdio_in};
    assign data_byte  = lsb_first_reg ? rev8(data_raw) : data_raw;
    assign instr_done = (state_reg == PCLCR_INSTR) && sclk_rise && (bit_cnt_reg == INSTR_LAST_BIT);
    assign byte_done  = (state_reg == PCLCR_DATA) && sclk_rise && (bit_cnt_reg == DATA_LAST_BIT);
    assign wr_now     = byte_done && !read_reg;
    assign first_addr = instr_word[12:0];
    // lsb-first frames walk upward, msb-first frames walk downward
    assign next_addr  = lsb_first_reg ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
    assign out_idx    = lsb_first_reg ? bit_cnt_reg[2:0] : 3'h7 - bit_cnt_reg[2:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg    <= PCLCR_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 15'h0000;
            read_reg     <= 1'b0;
            addr_reg     <= 13'h0000;
            out_byte_reg <= 8'h00;
        end else if (csb_n) begin
            state_reg   <= PCLCR_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                PCLCR_IDLE: begin
                    state_reg   <= PCLCR_INSTR;
                    bit_cnt_reg <= 4'h0;
                end
                PCLCR_INSTR: begin
                    if (sclk_rise) begin
                        shift_reg   <= instr_raw[14:0];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (instr_done) begin
                        state_reg    <= PCLCR_DATA;
                        bit_cnt_reg  <= 4'h0;
                        read_reg     <= instr_word[INSTR_RW_BIT];
                        addr_reg     <= first_addr;
                        out_byte_reg <= read_mux(first_addr);
                    end
                end
                PCLCR_DATA: begin
                    if (sclk_rise) begin
                        shift_reg   <= instr_raw[14:0];
                        bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
                    end
                    // streaming: keep walking until chip select rises
                    if (byte_done) begin
                        addr_reg     <= next_addr;
                        out_byte_reg <= read_mux(next_addr);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdio_out_reg <= 1'b0;
            sdio_oe_reg  <= 1'b0;
            sdo_out_reg  <= 1'b0;
            sdo_oe_reg   <= 1'b1;
        end else begin
            sdo_oe_reg <= ~sdo_inactive_reg;
            if (csb_n || state_reg != PCLCR_DATA || !read_reg) begin
                sdio_oe_reg <= 1'b0;
            end else if (sclk_fall) begin
                sdio_out_reg <= out_byte_reg[out_idx];
                sdo_out_reg  <= out_byte_reg[out_idx];
                sdio_oe_reg  <= sdo_inactive_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // address 0x00 is untouched by soft reset so the host can release it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_inactive_reg <= SDO_INACTIVE_RST;
            lsb_first_reg    <= LSB_FIRST_RST;
            soft_reset_reg   <= SOFT_RESET_RST;
        end else if (wr_now && addr_reg == SERIAL_PORT_CONFIG_OFS) begin
            sdo_inactive_reg <= data_byte[SPC_SDO_INACTIVE_BIT];
            lsb_first_reg    <= data_byte[SPC_LSB_FIRST_BIT];
            soft_reset_reg   <= data_byte[SPC_SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divider_reg.swallow_count <= SWALLOW_RST;
            divider_reg.main_count    <= MAIN_COUNT_RST;
            lor_cfg_reg.enable        <= LOR_ENABLE_RST;
            lor_cfg_reg.delay_code    <= LOR_DELAY_RST;
        end else if (soft_reset_reg) begin
            divider_reg.swallow_count <= SWALLOW_RST;
            divider_reg.main_count    <= MAIN_COUNT_RST;
            lor_cfg_reg.enable        <= LOR_ENABLE_RST;
            lor_cfg_reg.delay_code    <= LOR_DELAY_RST;
        end else if (wr_now) begin
            // unused bits and addresses are dropped
            unique case (addr_reg)
                SWALLOW_COUNT_OFS:   divider_reg.swallow_count <= data_byte[5:0];
                MAIN_COUNT_HIGH_OFS: divider_reg.main_count[12:8] <= data_byte[4:0];
                MAIN_COUNT_LOW_OFS:  divider_reg.main_count[7:0] <= data_byte;
                REFERENCE_LOSS_CONTROL_OFS: begin
                    lor_cfg_reg.enable     <= data_byte[RLC_ENABLE_BIT];
                    lor_cfg_reg.delay_code <= data_byte[RLC_DELAY_LSB + 1 -: 2];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // reference-loss monitor
    // ----------------------------------------------------------------
    always_comb begin
        unique case (lor_cfg_reg.delay_code)
            2'h0: lor_wait = LOR_WAIT_CODE0;
            2'h1: lor_wait = LOR_WAIT_CODE1;
            2'h2: lor_wait = LOR_WAIT_CODE2;
            2'h3: lor_wait = LOR_WAIT_CODE3;
        endcase
    end

    // a lost lock restarts the wait so a relock does not flag early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lor_cnt_reg   <= 5'h00;
            lor_armed_reg <= 1'b0;
        end else if (!lor_cfg_reg.enable || !lock_detect || soft_reset_reg) begin
            lor_cnt_reg   <= 5'h00;
            lor_armed_reg <= 1'b0;
        end else if (phase_detector_tick && !lor_armed_reg) begin
            lor_cnt_reg <= lor_cnt_reg + 5'h01;
            if (lor_cnt_reg + 5'h01 == lor_wait) begin
                lor_armed_reg <= 1'b1;
            end
        end
    end

    // flag is sticky until the monitor is switched off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lor_flag_reg <= 1'b0;
        end else if (!lor_cfg_reg.enable || soft_reset_reg) begin
            lor_flag_reg <= 1'b0;
        end else if (lor_armed_reg && phase_detector_tick && reference_missing) begin
            lor_flag_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_pin_reg <= 1'b0;
        end else begin
            status_pin_reg <= (status_pin_select == STATUS_SEL_LOR) && lor_flag_reg;
        end
    end

    assign sdio_out               = sdio_out_reg;
    assign sdio_oe                = sdio_oe_reg;
    assign serial_out_pin         = sdo_out_reg;
    assign serial_out_pin_oe      = sdo_oe_reg;
    assign divider                = divider_reg;
    assign lor_cfg                = lor_cfg_reg;
    assign reference_loss_monitor = lor_flag_reg;
    assign status_pin             = status_pin_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_pin_exclusive: assert property (@(posedge clk) disable iff (rst)
        sdio_oe |-> !serial_out_pin_oe)
        else $error("data pin and serial out pin driven together");

    a_sdo_default: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> serial_out_pin_oe && !sdio_oe)
        else $error("serial out pin not active after reset");

    a_swallow_write: assert property (@(posedge clk) disable iff (rst)
        (wr_now && addr_reg == SWALLOW_COUNT_OFS && !soft_reset_reg)
        |=> divider.swallow_count == $past(data_byte[5:0]))
        else $error("swallow count write lost");

    a_main_split: assert property (@(posedge clk) disable iff (rst)
        (wr_now && addr_reg == MAIN_COUNT_HIGH_OFS && !soft_reset_reg)
        |=> divider.main_count[12:8] == $past(data_byte[4:0])
            && divider.main_count[7:0] == $past(divider.main_count[7:0]))
        else $error("main count high write wrong");

    a_lor_off: assert property (@(posedge clk) disable iff (rst)
        !lor_cfg.enable |=> !reference_loss_monitor ##1 !reference_loss_monitor || lor_cfg.enable)
        else $error("loss flag while monitor disabled");

    a_lor_wait: assert property (@(posedge clk) disable iff (rst)
        $rose(lor_armed_reg) |-> $past(lor_cnt_reg) + 5'h01 == $past(lor_wait))
        else $error("monitor armed after wrong wait");

    a_soft_reset: assert property (@(posedge clk) disable iff (rst)
        soft_reset_reg |=> divider.swallow_count == SWALLOW_RST
            && divider.main_count == MAIN_COUNT_RST && !lor_cfg.enable)
        else $error("soft reset left a register set");

    a_status_lor: assert property (@(posedge clk) disable iff (rst)
        (status_pin_select == STATUS_SEL_LOR) |=> status_pin == $past(reference_loss_monitor))
        else $error("status pin does not follow loss flag");

    a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        (reference_loss_monitor && lor_cfg.enable && !soft_reset_reg) |=> reference_loss_monitor)
        else $error("loss flag dropped while enabled");

endmodule
